/* mchp_map.vh */
// Address map, status layout, command headers and timing counts of the mouse and clock port.
// Assumes an 8-bit host I/O bus with a 10-bit port address and one 40 MHz clock.
`ifndef MCHP_MAP_VH
`define MCHP_MAP_VH
// ==========================================================================
// Host port addresses
`define MCHP_ADDR_DATA 10'h2FC
`define MCHP_ADDR_RST_CLR 10'h2FD
`define MCHP_ADDR_CMDSTAT 10'h2FE
`define MCHP_ADDR_RST_SET 10'h2FF
// ==========================================================================
// Status bit positions
`define MCHP_ST_OUT_FULL 0
`define MCHP_ST_IN_FULL 1
`define MCHP_ST_SPARE 2
`define MCHP_ST_CMD 3
`define MCHP_ST_BTN_LO 4
`define MCHP_ST_PWR_FAIL 7
// ==========================================================================
// Command headers and their byte counts, header included
`define MCHP_CMD_SET_TIME 8'h01
`define MCHP_CMD_READ_TIME 8'h02
`define MCHP_CMD_BUTTON 8'h04
`define MCHP_CMD_MOTION 8'h08
`define MCHP_CMD_TIMER 8'h20
`define MCHP_LEN_SET_TIME 3'h5
`define MCHP_LEN_READ_TIME 3'h1
`define MCHP_LEN_PARAM 3'h2
// ==========================================================================
// Packet headers
`define MCHP_HDR_ALL 8'h41
`define MCHP_HDR_BUTTON 8'h42
`define MCHP_HDR_MOTION 8'h4D
`define MCHP_HDR_TIME 8'h52
// ==========================================================================
// Timing
`define MCHP_CLK_HZ 40000000
`define MCHP_TIMED_RATE_HZ 40
`define MCHP_TIMED_CYCLES (`MCHP_CLK_HZ / `MCHP_TIMED_RATE_HZ)
`define MCHP_POLL_CYCLES 16'h0040
`define MCHP_RTC_BIT_CYCLES 8'h10
`define MCHP_IRQ_PULSE 4'h4
`endif

/* mchp_rtc_link.v */
// Bit-serial exchange of the four time fields with the calendar chip.
// Assumes the chip latches rtc_sdo on rising rtc_sclk and drives rtc_sdi steadily.
`timescale 1ns/10ps
`default_nettype none
`include "mchp_map.vh"
module mchp_rtc_link (
    input wire clock,
    input wire rst_b,
    input wire ce,
    input wire start,
    input wire wr_mode,
    input wire [31:0] wr_data,
    output reg busy,
    output reg done,
    output reg [31:0] rd_data,
    output reg rtc_sclk,
    output reg rtc_sdo,
    input wire rtc_sdi
);
    reg [7:0] div_r;
    reg [5:0] bit_r;
    reg [31:0] sh_r;

    // ======================================================================
    // Shifter
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            done <= 1'b0;
            rd_data <= 32'h0000_0000;
            rtc_sclk <= 1'b0;
            rtc_sdo <= 1'b0;
            div_r <= 8'h00;
            bit_r <= 6'h00;
            sh_r <= 32'h0000_0000;
        end else if (ce) begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    sh_r <= wr_mode ? wr_data : 32'h0000_0000;
                    bit_r <= 6'h00;
                    div_r <= 8'h00;
                end
            end else if (div_r == `MCHP_RTC_BIT_CYCLES - 8'h01) begin
                div_r <= 8'h00;
                rtc_sclk <= ~rtc_sclk;
                if (!rtc_sclk) begin
                    rtc_sdo <= sh_r[31];
                end else begin
                    sh_r <= {sh_r[30:0], rtc_sdi};
                    bit_r <= bit_r + 6'h01;
                    if (bit_r == 6'h1F) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        rd_data <= {sh_r[30:0], rtc_sdi};
                    end
                end
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* mchp_port.v */
// Host command and data port of the mouse and calendar board.
// Assumes synchronous host strobes of one cycle, a 10-bit port address and debounced buttons.
`timescale 1ns/10ps
`default_nettype none
`include "mchp_map.vh"
module mchp_port (
    input wire clock,
    input wire rst_b,
    input wire ce,
    input wire [9:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    output reg host_irq_line_three,
    input wire [2:0] button_up,
    input wire [15:0] delta_x,
    input wire [15:0] delta_y,
    input wire motion_step,
    output reg motion_clear,
    input wire cal_power_fail,
    output reg rtc_sclk,
    output reg rtc_sdo,
    input wire rtc_sdi
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_CHECK = 5'h02;
    localparam [4:0] ST_RTC = 5'h04;
    localparam [4:0] ST_SEND = 5'h08;
    localparam [4:0] ST_WAIT = 5'h10;

    reg [4:0] state_r;
    reg ctl_rst_r;
    reg [7:0] in_reg_r;
    reg input_full_flag_r;
    reg output_full_flag_r;
    reg command_flag_r;
    reg pwr_fail_r;
    reg [7:0] out_reg_r;
    reg [7:0] ibuf_r [0:4];
    reg [2:0] icnt_r;
    reg [7:0] obuf_r [0:4];
    reg [2:0] olen_r;
    reg [2:0] optr_r;
    reg [7:0] motion_lim_r;
    reg [7:0] motion_cnt_r;
    reg button_en_r;
    reg timer_en_r;
    reg [2:0] btn_last_r;
    reg [19:0] tick_r;
    reg [15:0] poll_r;
    reg [3:0] irq_cnt_r;
    reg rtc_start_r;
    reg rtc_wr_r;
    reg moved_r;
    wire rtc_busy;
    wire rtc_done;
    wire [31:0] rtc_rd;
    wire rtc_sclk_w;
    wire rtc_sdo_w;
    integer i;

    // Header plus payload length check; unknown headers never match.
    function cmd_ok;
        input [7:0] hdr;
        input [2:0] cnt;
        begin
            if (hdr == `MCHP_CMD_SET_TIME) begin
                cmd_ok = (cnt == `MCHP_LEN_SET_TIME);
            end else if (hdr == `MCHP_CMD_READ_TIME) begin
                cmd_ok = (cnt == `MCHP_LEN_READ_TIME);
            end else if (hdr == `MCHP_CMD_MOTION || hdr == `MCHP_CMD_BUTTON
                         || hdr == `MCHP_CMD_TIMER) begin
                cmd_ok = (cnt == `MCHP_LEN_PARAM);
            end else begin
                cmd_ok = 1'b0;
            end
        end
    endfunction

    wire hit_data = (io_addr == `MCHP_ADDR_DATA);
    wire hit_cmd = (io_addr == `MCHP_ADDR_CMDSTAT);
    // Buttons read live, so the status shows them even with button reporting off.
    wire [7:0] status_w = {pwr_fail_r, button_up, command_flag_r, 1'b0,
                           input_full_flag_r, output_full_flag_r};
    wire motion_due = (motion_lim_r != 8'h00 && motion_cnt_r >= motion_lim_r);
    wire run = ~ctl_rst_r;

    mchp_rtc_link u_rtc (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .start(rtc_start_r),
        .wr_mode(rtc_wr_r),
        .wr_data({ibuf_r[1], ibuf_r[2], ibuf_r[3], ibuf_r[4]}),
        .busy(rtc_busy),
        .done(rtc_done),
        .rd_data(rtc_rd),
        .rtc_sclk(rtc_sclk_w),
        .rtc_sdo(rtc_sdo_w),
        .rtc_sdi(rtc_sdi)
    );

    // ======================================================================
    // Host side: decode, status, reset latch
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl_rst_r <= 1'b0;
            io_rdata <= 8'h00;
            in_reg_r <= 8'h00;
            input_full_flag_r <= 1'b0;
        end else if (ce) begin
            if (io_wr && io_addr == `MCHP_ADDR_RST_SET) begin
                ctl_rst_r <= 1'b1;
            end else if (io_wr && io_addr == `MCHP_ADDR_RST_CLR) begin
                ctl_rst_r <= 1'b0;
            end
            if (io_rd && hit_data) begin
                io_rdata <= out_reg_r;
            end else if (io_rd && hit_cmd) begin
                io_rdata <= status_w;
            end
            // A host write wins over the controller's clear in the same cycle.
            if (io_wr && (hit_data || hit_cmd)) begin
                in_reg_r <= io_wdata;
                input_full_flag_r <= 1'b1;
            end else if (run && input_full_flag_r) begin
                input_full_flag_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Controller processing cycle
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            output_full_flag_r <= 1'b0;
            command_flag_r <= 1'b0;
            pwr_fail_r <= 1'b0;
            out_reg_r <= 8'h00;
            icnt_r <= 3'h0;
            olen_r <= 3'h0;
            optr_r <= 3'h0;
            motion_lim_r <= 8'h00;
            motion_cnt_r <= 8'h00;
            button_en_r <= 1'b0;
            timer_en_r <= 1'b0;
            btn_last_r <= 3'h7;
            tick_r <= 20'h00000;
            poll_r <= 16'h0000;
            irq_cnt_r <= 4'h0;
            host_irq_line_three <= 1'b0;
            rtc_start_r <= 1'b0;
            rtc_wr_r <= 1'b0;
            moved_r <= 1'b0;
            motion_clear <= 1'b0;
            rtc_sclk <= 1'b0;
            rtc_sdo <= 1'b0;
            for (i = 0; i < 5; i = i + 1) begin
                ibuf_r[i] <= 8'h00;
                obuf_r[i] <= 8'h00;
            end
        end else if (ce) begin
            rtc_sclk <= rtc_sclk_w;
            rtc_sdo <= rtc_sdo_w;
            rtc_start_r <= 1'b0;
            motion_clear <= 1'b0;
            if (io_rd && hit_data) begin
                output_full_flag_r <= 1'b0;
            end
            if (io_wr && hit_cmd) begin
                command_flag_r <= 1'b1;
            end
            if (cal_power_fail) begin
                pwr_fail_r <= 1'b1;
            end
            if (irq_cnt_r != 4'h0) begin
                irq_cnt_r <= irq_cnt_r - 4'h1;
            end
            host_irq_line_three <= (irq_cnt_r != 4'h0);
            if (ctl_rst_r) begin
                // Held controller clears state, counts, output full and command flags, enables, irq; power fail, moved, motion count, tick, poll hold.
                state_r <= ST_IDLE;
                output_full_flag_r <= 1'b0;
                command_flag_r <= 1'b0;
                icnt_r <= 3'h0;
                olen_r <= 3'h0;
                optr_r <= 3'h0;
                motion_lim_r <= 8'h00;
                button_en_r <= 1'b0;
                timer_en_r <= 1'b0;
                irq_cnt_r <= 4'h0;
                host_irq_line_three <= 1'b0;
            end else begin
                if (input_full_flag_r && icnt_r < 3'h5 && state_r != ST_RTC) begin
                    ibuf_r[icnt_r] <= in_reg_r;
                    icnt_r <= icnt_r + 3'h1;
                end
                if (motion_step) begin
                    moved_r <= 1'b1;
                    motion_cnt_r <= motion_cnt_r + 8'h01;
                end
                tick_r <= (tick_r >= `MCHP_TIMED_CYCLES - 1) ? 20'h00000 : tick_r + 20'h00001;
                case (state_r)
                ST_IDLE: begin
                    poll_r <= poll_r + 16'h0001;
                    if (olen_r == 3'h0 && button_en_r && button_up != btn_last_r) begin
                        btn_last_r <= button_up;
                        obuf_r[0] <= `MCHP_HDR_BUTTON;
                        olen_r <= 3'h1;
                        optr_r <= 3'h0;
                        state_r <= ST_SEND;
                    end else if (olen_r == 3'h0 && (motion_due
                                 || (timer_en_r && moved_r && tick_r == 20'h00000))) begin
                        obuf_r[0] <= motion_due ? `MCHP_HDR_MOTION : `MCHP_HDR_ALL;
                        {obuf_r[1], obuf_r[2]} <= delta_x;
                        {obuf_r[3], obuf_r[4]} <= delta_y;
                        olen_r <= 3'h5;
                        optr_r <= 3'h0;
                        motion_cnt_r <= 8'h00;
                        moved_r <= 1'b0;
                        motion_clear <= 1'b1;
                        state_r <= ST_SEND;
                    end else if (command_flag_r && !input_full_flag_r) begin
                        state_r <= ST_CHECK;
                    end else if (poll_r >= `MCHP_POLL_CYCLES) begin
                        poll_r <= 16'h0000;
                        if (output_full_flag_r) begin
                            irq_cnt_r <= `MCHP_IRQ_PULSE;
                        end else if (optr_r < olen_r) begin
                            state_r <= ST_SEND;
                        end
                    end
                end
                ST_CHECK: begin
                    // Both outcomes drop the buffer and count; the flag stays set only for a command write in this cycle.
                    icnt_r <= 3'h0;
                    command_flag_r <= io_wr && hit_cmd;
                    state_r <= ST_IDLE;
                    if (cmd_ok(ibuf_r[0], icnt_r)) begin
                        if (ibuf_r[0] == `MCHP_CMD_MOTION) begin
                            motion_lim_r <= ibuf_r[1];
                            motion_cnt_r <= 8'h00;
                        end else if (ibuf_r[0] == `MCHP_CMD_BUTTON) begin
                            button_en_r <= (ibuf_r[1] != 8'h00);
                            btn_last_r <= button_up;
                        end else if (ibuf_r[0] == `MCHP_CMD_TIMER) begin
                            timer_en_r <= (ibuf_r[1] != 8'h00);
                        end else begin
                            rtc_wr_r <= (ibuf_r[0] == `MCHP_CMD_SET_TIME);
                            rtc_start_r <= 1'b1;
                            state_r <= ST_RTC;
                        end
                    end
                end
                ST_RTC: begin
                    // Motion and tick counting go on here; bytes written now are never stored, yet input full still clears.
                    if (rtc_done) begin
                        state_r <= ST_IDLE;
                        if (rtc_wr_r && !cal_power_fail) begin
                            pwr_fail_r <= 1'b0;
                        end
                        if (!rtc_wr_r) begin
                            obuf_r[0] <= `MCHP_HDR_TIME;
                            obuf_r[1] <= rtc_rd[31:24];
                            obuf_r[2] <= rtc_rd[23:16];
                            obuf_r[3] <= rtc_rd[15:8];
                            obuf_r[4] <= rtc_rd[7:0];
                            olen_r <= 3'h5;
                            optr_r <= 3'h0;
                            state_r <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    if (!output_full_flag_r) begin
                        out_reg_r <= obuf_r[optr_r];
                        output_full_flag_r <= 1'b1;
                        irq_cnt_r <= `MCHP_IRQ_PULSE;
                        poll_r <= 16'h0000; // Keeps a re-signal from merging pulses.
                        optr_r <= optr_r + 3'h1;
                        if (optr_r + 3'h1 == olen_r) begin
                            state_r <= ST_WAIT;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    // Last byte out; the packet slot frees once the host reads it.
                    if (!output_full_flag_r) begin
                        olen_r <= 3'h0;
                        optr_r <= 3'h0;
                        state_r <= ST_IDLE;
                    end else if (poll_r >= `MCHP_POLL_CYCLES) begin
                        poll_r <= 16'h0000;
                        irq_cnt_r <= `MCHP_IRQ_PULSE;
                    end else begin
                        poll_r <= poll_r + 16'h0001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* mchp_port_asserts.sv */
// Concurrent checks on the host port of the mouse and calendar block.
// Assumes one clock domain and sees only the ports of the top module.
`timescale 1ns/10ps
`default_nettype none
`include "mchp_map.vh"
module mchp_port_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic host_irq_line_three,
    input wire logic motion_clear,
    input wire logic rtc_sclk,
    input wire logic rtc_sdo
);
    // ======================================================================
    // Helper logic
    // A counter keeps the half-period check cheap instead of a long repetition.
    logic [5:0] hi_cnt_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt_r <= 6'h00;
        end else begin
            hi_cnt_r <= rtc_sclk ? hi_cnt_r + 6'h01 : 6'h00;
        end
    end
    // ======================================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    rdata_source_a: assert property ($changed(io_rdata) |-> $past(io_rd) &&
        ($past(io_addr) == `MCHP_ADDR_DATA || $past(io_addr) == `MCHP_ADDR_CMDSTAT))
        else $error("read data changed without a read of a mapped port");
    reset_quiet_a: assert property ($rose(rst_b) |-> io_rdata == 8'h00 &&
        !host_irq_line_three && !motion_clear && !rtc_sclk)
        else $error("outputs not cleared by reset");
    held_quiet_a: assert property ((io_wr && io_addr == `MCHP_ADDR_RST_SET) ##1
        (!(io_wr && io_addr == `MCHP_ADDR_RST_CLR))[*8] |-> !host_irq_line_three && !motion_clear)
        else $error("controller active while held in reset");
    irq_pulse_a: assert property ($rose(host_irq_line_three) |->
        host_irq_line_three[*4] ##1 !host_irq_line_three)
        else $error("interrupt pulse length wrong");
    motion_pulse_a: assert property (motion_clear |=> !motion_clear)
        else $error("motion clear longer than one cycle");
    sclk_half_a: assert property ($fell(rtc_sclk) |-> hi_cnt_r == 6'h10)
        else $error("serial clock high half wrong");
    sdo_steady_a: assert property (rtc_sclk && $past(rtc_sclk) |-> $stable(rtc_sdo))
        else $error("serial data moved while clock high");
    time_quiet_a: assert property (rtc_sclk |-> !$rose(host_irq_line_three))
        else $error("interrupt raised during time exchange");
endmodule
bind mchp_port mchp_port_chk mchp_port_chk_inst (.clock(clock), .rst_b(rst_b),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .host_irq_line_three(host_irq_line_three), .motion_clear(motion_clear),
    .rtc_sclk(rtc_sclk), .rtc_sdo(rtc_sdo));
`default_nettype wire

/* mchp_host_model.sv */
// Host processor model: single-cycle read and write strobes on the port bus.
// Assumes inputs change on the falling clock edge and read data settles one cycle later.
`timescale 1ns/10ps
`default_nettype none
`include "mchp_map.vh"
module mchp_host_model (
    input wire logic clock,
    output logic [9:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    // ======================================================================
    // Bus cycles
    initial begin
        io_addr = 10'h000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // Released data shows the inverse of the last byte, so stale data cannot pass.
    task automatic put(input logic [9:0] a, input logic [7:0] d);
        @(negedge clock);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clock);
        io_wr = 1'b0;
        io_wdata = ~d;
    endtask
    task automatic get(input logic [9:0] a, output logic [7:0] d);
        @(negedge clock);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clock);
        io_rd = 1'b0;
        d = io_rdata;
    endtask
    // Polls input full; after a millisecond the controller is taken as hung.
    task automatic send(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] s;
        int n = 0;
        get(`MCHP_ADDR_CMDSTAT, s);
        while (s[`MCHP_ST_IN_FULL] !== 1'b0 && n < 20000) begin
            get(`MCHP_ADDR_CMDSTAT, s);
            n++;
        end
        if (n == 20000) begin
            put(`MCHP_ADDR_RST_SET, 8'h00);
            put(`MCHP_ADDR_RST_CLR, 8'h00);
        end
        put(a, d);
    endtask
    task automatic cmd(input logic [7:0] b [5], input int n);
        for (int i = 0; i < n; i++) begin
            send(i == n - 1 ? `MCHP_ADDR_CMDSTAT : `MCHP_ADDR_DATA, b[i]);
        end
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the mouse and calendar host port.
// Assumes the host model drives the bus; this module plays mouse and calendar chip.
`timescale 1ns/10ps
`default_nettype none
`include "mchp_map.vh"
module tb_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic host_irq_line_three;
    logic motion_clear;
    logic rtc_sclk;
    logic rtc_sdo;
    logic [2:0] button_up = 3'h7;
    logic [15:0] delta_x = 16'h0000;
    logic [15:0] delta_y = 16'h0000;
    logic motion_step = 1'b0;
    logic cal_power_fail = 1'b0;
    logic sclk_was = 1'b0;
    logic [31:0] cal_word = 32'h0000_0000;
    logic [31:0] sdo_word = 32'h0000_0000;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int irqs = 0;
    int clears = 0;
    logic irq_was = 1'b0;
    always #12.5 clock = ~clock;
    mchp_port mchp_port_inst (.clock(clock), .rst_b(rst_b), .ce(1'b1), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .host_irq_line_three(host_irq_line_three), .button_up(button_up),
        .delta_x(delta_x), .delta_y(delta_y), .motion_step(motion_step),
        .motion_clear(motion_clear), .cal_power_fail(cal_power_fail),
        .rtc_sclk(rtc_sclk), .rtc_sdo(rtc_sdo), .rtc_sdi(cal_word[31]));
    mchp_host_model mchp_host_model_inst (.clock(clock), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
    // ======================================================================
    // Calendar chip: shifts on the falling serial clock so bits are steady when sampled
    always @(negedge clock) begin
        if (sclk_was && !rtc_sclk) begin
            cal_word <= {cal_word[30:0], ~cal_word[31]};
        end
        if (!sclk_was && rtc_sclk) begin
            sdo_word <= {sdo_word[30:0], rtc_sdo};
        end
        if (host_irq_line_three && !irq_was) begin
            irqs++;
        end
        if (motion_clear) begin
            clears++;
        end
        irq_was <= host_irq_line_three;
        sclk_was <= rtc_sclk;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ======================================================================
    // Checking helpers
    function automatic logic [7:0] stat_exp(input logic [2:0] b, input logic pf);
        return {pf, b, 4'h0};
    endfunction
    function automatic logic [7:0] bcd(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic expect_pkt(input logic [7:0] e [5], input int n);
        logic [7:0] s;
        logic [7:0] d;
        int k;
        int i0;
        i0 = irqs;
        for (int i = 0; i < n; i++) begin
            s = 8'h00;
            k = 0;
            while (s[`MCHP_ST_OUT_FULL] !== 1'b1 && k < 2000) begin
                mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
                k++;
            end
            mchp_host_model_inst.get(`MCHP_ADDR_DATA, d);
            check("packet byte", d, e[i]);
        end
        repeat (200) @(negedge clock);
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("packet irq", irqs > i0, 1'b1);
        check("packet end", s, stat_exp(button_up, 1'b0));
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ======================================================================
    // Main sequence
    initial begin
        logic [7:0] s;
        logic [7:0] d;
        logic [7:0] t [4];
        int r;
        int np;
        r = $urandom(98);
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            button_up = r[2:0];
            repeat (150) @(negedge clock);
            mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
            check("status", s, stat_exp(button_up, 1'b0));
        end
        mchp_host_model_inst.get(10'h2FB, d);
        check("unmapped read", d, s);
        mchp_host_model_inst.cmd('{`MCHP_CMD_MOTION, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        repeat (200) @(negedge clock);
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("short command", s, stat_exp(button_up, 1'b0));
        r = $urandom;
        delta_x = r[15:0];
        delta_y = r[31:16];
        np = r[1:0] + 1;
        mchp_host_model_inst.cmd('{`MCHP_CMD_MOTION, 8'(np), 8'h00, 8'h00, 8'h00}, 2);
        repeat (200) @(negedge clock);
        repeat (np) begin
            motion_step = 1'b1;
            @(negedge clock);
            motion_step = 1'b0;
            @(negedge clock);
        end
        expect_pkt('{`MCHP_HDR_MOTION, delta_x[15:8], delta_x[7:0], delta_y[15:8],
            delta_y[7:0]}, 5);
        check("motion clear", clears, 1);
        mchp_host_model_inst.cmd('{`MCHP_CMD_MOTION, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
        mchp_host_model_inst.cmd('{`MCHP_CMD_BUTTON, 8'h01, 8'h00, 8'h00, 8'h00}, 2);
        repeat (200) @(negedge clock);
        button_up = ~button_up;
        expect_pkt('{`MCHP_HDR_BUTTON, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        mchp_host_model_inst.cmd('{`MCHP_CMD_BUTTON, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
        cal_power_fail = 1'b1;
        repeat (150) @(negedge clock);
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("power failed", s, stat_exp(button_up, 1'b1));
        cal_power_fail = 1'b0;
        for (int i = 0; i < 4; i++) begin
            t[i] = bcd($urandom % 12 + 1);
        end
        mchp_host_model_inst.cmd('{`MCHP_CMD_SET_TIME, t[0], t[1], t[2], t[3]}, 5);
        repeat (2500) @(negedge clock);
        check("time sent", sdo_word, {t[0], t[1], t[2], t[3]});
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("power restored", s, stat_exp(button_up, 1'b0));
        for (int i = 0; i < 4; i++) begin
            t[i] = bcd($urandom % 12 + 1);
        end
        cal_word = {t[0], t[1], t[2], t[3]};
        mchp_host_model_inst.cmd('{`MCHP_CMD_READ_TIME, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        expect_pkt('{`MCHP_HDR_TIME, t[0], t[1], t[2], t[3]}, 5);
        mchp_host_model_inst.put(`MCHP_ADDR_RST_SET, 8'h00);
        mchp_host_model_inst.put(`MCHP_ADDR_DATA, 8'h55);
        repeat (20) @(negedge clock);
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("held input full", s[1], 1'b1);
        mchp_host_model_inst.put(`MCHP_ADDR_RST_CLR, 8'h00);
        repeat (200) @(negedge clock);
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("input drained", s[1], 1'b0);
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        repeat (150) @(negedge clock);
        mchp_host_model_inst.get(`MCHP_ADDR_CMDSTAT, s);
        check("after reset", s, stat_exp(button_up, 1'b0));
        tally_and_finish();
    end
endmodule
`default_nettype wire
